// *** hdl/mhb_pkg.sv ***
// Purpose: Shared constants for the multiplexed host bus port, both ends.
// Assumes: One 40 MHz clock; pin levels are raw, polarity set by config.
// Notes: Timing figures in ns, cycle counts derived from the clock period.
package mhb_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 25;
	// Minimum host timings from the cycle tables
	localparam int T_WALE_NS = 10;
	localparam int T_RD_NS = 32;
	localparam int T_RDALE_NS = 13;
	localparam int T_ALERD_NS = 5;
	// Least times round up, never below one cycle
	localparam int ALE_CYC = (T_WALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STB_MIN_CYC = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = (T_RDALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (T_ALERD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Extra margin for the device's pin synchronisers and data fetch
	localparam int SYNC_MARGIN_CYC = 6;
	localparam int STB_CYC = STB_MIN_CYC + SYNC_MARGIN_CYC;
	localparam int REL_CYC = GAP_CYC + 3;
	localparam logic [3:0] CNT_W1 = 4'h1;
	// Device cycle state
	typedef enum logic [1:0] {
		MHB_D_IDLE = 2'b00,
		MHB_D_READ = 2'b01,
		MHB_D_WRITE = 2'b10
	} mhb_dstate_t;
	// Host sequencer state, Gray from idle through release along the dual-phase path
	typedef enum logic [2:0] {
		MHB_H_IDLE = 3'b000,
		MHB_H_ALE1 = 3'b001,
		MHB_H_GAP1 = 3'b011,
		MHB_H_ALE2 = 3'b010,
		MHB_H_SETUP = 3'b110,
		MHB_H_STB = 3'b111,
		MHB_H_REL = 3'b101
	} mhb_hstate_t;
endpackage

// *** hdl/mhb_if.sv ***
// Purpose: Pin bundle between the host end and the device end.
// Assumes: Raw pin levels; each end applies its own polarity settings.
// Notes: The shared address/data wire is resolved here from both enables.
`timescale 1ns/100ps
interface mhb_if;
	import mhb_pkg::*;
	logic ale_lo; // Address latch low strobe pin
	logic ale_hi; // Address latch high strobe pin
	logic cs; // Chip select pin
	logic rd; // Read strobe, or direction line
	logic wr; // Write strobe, or cycle enable strobe
	logic [DATA_W-1:0] ad_host;
	logic ad_host_oe;
	logic [DATA_W-1:0] ad_dev;
	logic ad_dev_oe;
	logic [DATA_W-1:0] ad;
	// Reads as zero when neither end drives; a clash shows as unknown
	assign ad = (ad_host_oe && ad_dev_oe) ? 'x :
		ad_host_oe ? ad_host : ad_dev_oe ? ad_dev : '0;
	modport host (
		output ale_lo, ale_hi, cs, rd, wr, ad_host, ad_host_oe,
		input ad
	);
	modport dev (
		input ale_lo, ale_hi, cs, rd, wr, ad,
		output ad_dev, ad_dev_oe
	);
endinterface

// *** hdl/mhb_dev.sv ***
// Purpose: Device end of the multiplexed host bus port.
// Assumes: Pins are asynchronous to clk_i and pass two flip-flops first.
// Notes: Reads fetch user data one cycle after the read pulse.
`timescale 1ns/100ps
module mhb_dev
	import mhb_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	mhb_if.dev bus,
	input wire logic cfg_enable_mode_i,
	input wire logic cfg_ale_qual_i,
	input wire logic cfg_dual_phase_i,
	input wire logic cfg_ale_pol_i,
	input wire logic cfg_cs_pol_i,
	input wire logic cfg_rd_pol_i,
	input wire logic cfg_wr_pol_i,
	input wire logic [DATA_W-1:0] rdata_i,
	output logic rd_req_o,
	output logic wr_req_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [DATA_W-1:0] wdata_o,
	output logic busy_o
);
	localparam int NPIN = 5;
	// Two-stage synchronisers for every incoming pin
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic [NPIN-1:0] pin_d;
	logic [DATA_W-1:0] ad_s1;
	logic [DATA_W-1:0] ad_s2;
	logic [DATA_W-1:0] ad_d;
	wire [NPIN-1:0] pin_raw;
	assign pin_raw = {bus.wr, bus.rd, bus.cs, bus.ale_hi, bus.ale_lo};

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_d <= '0;
			ad_s1 <= '0;
			ad_s2 <= '0;
			ad_d <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
			ad_s1 <= bus.ad;
			ad_s2 <= ad_s1;
			ad_d <= ad_s2;
		end
	end

	// Polarity folding to active-high meanings
	wire [NPIN-1:0] pol;
	wire [NPIN-1:0] act_now;
	wire [NPIN-1:0] act_old;
	assign pol = {cfg_wr_pol_i, cfg_rd_pol_i, cfg_cs_pol_i, cfg_ale_pol_i,
		cfg_ale_pol_i};
	assign act_now = ~(pin_s2 ^ pol);
	assign act_old = ~(pin_d ^ pol);

	wire alo_raw;
	wire ahi_raw;
	wire cs_act;
	wire rd_act;
	wire wr_act;
	wire cs_old;
	assign alo_raw = act_now[0];
	assign ahi_raw = act_now[1];
	assign cs_act = act_now[2];
	assign rd_act = act_now[3];
	assign wr_act = act_now[4];
	assign cs_old = act_old[2];

	// Edges are ignored until the chain holds real pin levels; its reset
	// value is not the idle level under every polarity setting
	logic [1:0] warm;
	wire primed;
	assign primed = (warm == 2'h3);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			warm <= 2'h0;
		end else if (!primed) begin
			warm <= warm + 2'h1;
		end
	end

	// Latch strobes count only with select when qualification is on
	wire alo_q;
	wire ahi_q;
	wire alo_q_old;
	wire ahi_q_old;
	assign alo_q = alo_raw && (!cfg_ale_qual_i || cs_act);
	assign ahi_q = ahi_raw && (!cfg_ale_qual_i || cs_act);
	assign alo_q_old = act_old[0] && (!cfg_ale_qual_i || cs_old);
	assign ahi_q_old = act_old[1] && (!cfg_ale_qual_i || cs_old);

	// Release edges; synced address data lags equally so stays aligned
	wire alo_fall;
	wire ahi_fall;
	assign alo_fall = primed && alo_q_old && !alo_q;
	assign ahi_fall = primed && ahi_q_old && !ahi_q;

	// Cycle start and end decode for both signalling styles
	wire stb_rd;
	wire stb_wr;
	wire stb_rd_old;
	wire stb_wr_old;
	assign stb_rd = cfg_enable_mode_i ? (wr_act && rd_act) : rd_act;
	assign stb_wr = cfg_enable_mode_i ? (wr_act && !rd_act) : wr_act;
	assign stb_rd_old = cfg_enable_mode_i ? (act_old[4] && act_old[3]) :
		act_old[3];
	assign stb_wr_old = cfg_enable_mode_i ? (act_old[4] && !act_old[3]) :
		act_old[4];
	// Enable mode uses the enable line alone to end the cycle
	wire strobe_live;
	assign strobe_live = cfg_enable_mode_i ? wr_act :
		(rd_act || wr_act);
	wire start_rd;
	wire start_wr;
	assign start_rd = primed && stb_rd && !stb_rd_old && cs_act;
	assign start_wr = primed && stb_wr && !stb_wr_old && cs_act;

	mhb_dstate_t state;
	mhb_dstate_t next_state;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] rd_buf;
	logic rd_fetch;
	logic ad_oe;

	// Cycle state; any successor is taken from idle
	always_comb begin
		next_state = state;
		case (state)
			MHB_D_IDLE: begin
				if (start_rd) begin
					next_state = MHB_D_READ;
				end else if (start_wr) begin
					next_state = MHB_D_WRITE;
				end
			end
			MHB_D_READ: begin
				if (!strobe_live) begin
					next_state = MHB_D_IDLE;
				end
			end
			MHB_D_WRITE: begin
				if (!strobe_live) begin
					next_state = MHB_D_IDLE;
				end
			end
			default: begin
				next_state = MHB_D_IDLE;
			end
		endcase
	end

	wire write_end;
	assign write_end = (state == MHB_D_WRITE) && !strobe_live;

	// Address assembly; dual phase takes both halves from the low lane
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_q <= '0;
		end else if (cfg_dual_phase_i) begin
			if (alo_fall) begin
				addr_q[7:0] <= ad_d[7:0];
			end
			if (ahi_fall) begin
				addr_q[15:8] <= ad_d[7:0];
			end
		end else if (alo_fall || ahi_fall) begin
			addr_q <= ad_d;
		end
	end

	// State, user strobes and read data drive
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= MHB_D_IDLE;
			rd_req_o <= 1'b0;
			wr_req_o <= 1'b0;
			rd_fetch <= 1'b0;
			addr_o <= '0;
			wdata_o <= '0;
			rd_buf <= '0;
			ad_oe <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			state <= next_state;
			rd_req_o <= (state == MHB_D_IDLE) && start_rd;
			wr_req_o <= write_end;
			rd_fetch <= rd_req_o;
			busy_o <= (next_state != MHB_D_IDLE);
			if (state == MHB_D_IDLE) begin
				addr_o <= addr_q;
			end
			if (write_end) begin
				wdata_o <= ad_d; // Data held past strobe release
			end
			if (rd_fetch) begin
				rd_buf <= rdata_i;
			end
			// Drive only after fetch, release as soon as read ends
			ad_oe <= (state == MHB_D_READ) && strobe_live &&
				(rd_fetch || ad_oe);
		end
	end

	assign bus.ad_dev = rd_buf;
	assign bus.ad_dev_oe = ad_oe;
endmodule // mhb_dev

// *** hdl/mhb_host.sv ***
// Purpose: Host end driving the multiplexed host bus port.
// Assumes: Same clock as the user side; bus data pin is resynchronised.
// Notes: One command at a time; ready_o low while a command runs.
`timescale 1ns/100ps
module mhb_host
	import mhb_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	mhb_if.host bus,
	input wire logic cfg_enable_mode_i,
	input wire logic cfg_dual_phase_i,
	input wire logic cfg_hi_first_i,
	input wire logic cfg_ale_pol_i,
	input wire logic cfg_cs_pol_i,
	input wire logic cfg_rd_pol_i,
	input wire logic cfg_wr_pol_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_rd_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [DATA_W-1:0] cmd_wdata_i,
	output logic ready_o,
	output logic rdata_valid_o,
	output logic [DATA_W-1:0] rdata_o
);
	mhb_hstate_t state;
	logic [3:0] cnt;
	logic is_rd;
	logic pend_rd;
	logic dummy;
	logic after_wr;
	logic addr_ok;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] tgt_addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] ad_s1;
	logic [DATA_W-1:0] ad_s2;
	logic ale_lo;
	logic ale_hi;
	logic cs;
	logic rdl;
	logic wrl;
	logic [DATA_W-1:0] ad_out;
	logic ad_oe;

	wire cnt_done;
	wire accept;
	wire need_addr;
	wire first_lo;
	assign cnt_done = (cnt == CNT_W1);
	assign accept = (state == MHB_H_IDLE) && cmd_valid_i;
	assign need_addr = !addr_ok || (cmd_addr_i != cur_addr);
	// In single phase only the low strobe is used
	assign first_lo = !cfg_dual_phase_i || !cfg_hi_first_i;

	// Data pin resynchronised before it is read
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ad_s1 <= '0;
			ad_s2 <= '0;
		end else begin
			ad_s1 <= bus.ad;
			ad_s2 <= ad_s1;
		end
	end

	// Sequencer; a new address after a write is reached via a dummy read
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= MHB_H_IDLE;
			cnt <= '0;
			is_rd <= 1'b0;
			pend_rd <= 1'b0;
			dummy <= 1'b0;
			after_wr <= 1'b0;
			addr_ok <= 1'b0;
			cur_addr <= '0;
			tgt_addr <= '0;
			wdata <= '0;
			ready_o <= 1'b0;
			rdata_valid_o <= 1'b0;
			rdata_o <= '0;
			ale_lo <= 1'b0;
			ale_hi <= 1'b0;
			cs <= 1'b0;
			rdl <= 1'b0;
			wrl <= 1'b0;
			ad_out <= '0;
			ad_oe <= 1'b0;
		end else begin
			rdata_valid_o <= 1'b0;
			ready_o <= (state == MHB_H_IDLE) && !cmd_valid_i;
			cnt <= cnt_done ? cnt : cnt - CNT_W1;
			case (state)
				MHB_H_IDLE: begin
					if (accept) begin
						tgt_addr <= cmd_addr_i;
						wdata <= cmd_wdata_i;
						pend_rd <= cmd_rd_i;
						ready_o <= 1'b0;
						if (need_addr && after_wr) begin
							dummy <= 1'b1;
							is_rd <= 1'b1;
							state <= MHB_H_SETUP;
						end else if (need_addr) begin
							is_rd <= cmd_rd_i;
							state <= MHB_H_ALE1;
							ale_lo <= first_lo;
							ale_hi <= !first_lo;
							ad_out <= first_lo && cfg_dual_phase_i ?
								{8'h00, cmd_addr_i[7:0]} :
								first_lo ? cmd_addr_i :
								{8'h00, cmd_addr_i[15:8]};
							ad_oe <= 1'b1;
						end else begin
							is_rd <= cmd_rd_i;
							state <= MHB_H_SETUP;
						end
						cs <= 1'b1;
						cnt <= 4'(ALE_CYC);
					end
				end
				MHB_H_ALE1: begin
					if (cnt_done) begin
						ale_lo <= 1'b0;
						ale_hi <= 1'b0;
						cnt <= 4'(SETUP_CYC);
						state <= cfg_dual_phase_i ? MHB_H_GAP1 : MHB_H_SETUP;
					end
				end
				MHB_H_GAP1: begin
					// Address held one cycle past the strobe release
					ale_lo <= !first_lo;
					ale_hi <= first_lo;
					ad_out <= first_lo ? {8'h00, tgt_addr[15:8]} :
						{8'h00, tgt_addr[7:0]};
					cnt <= 4'(ALE_CYC);
					state <= MHB_H_ALE2;
				end
				MHB_H_ALE2: begin
					if (cnt_done) begin
						ale_lo <= 1'b0;
						ale_hi <= 1'b0;
						cnt <= 4'(SETUP_CYC);
						state <= MHB_H_SETUP;
					end
				end
				MHB_H_SETUP: begin
					// Direction line and enable strobe rise on the same edge, as SETUP_CYC and ALE_CYC are both one
					cur_addr <= tgt_addr;
					addr_ok <= 1'b1;
					ad_out <= wdata;
					ad_oe <= !is_rd;
					rdl <= cfg_enable_mode_i ? is_rd : 1'b0;
					if (cnt_done) begin
						rdl <= is_rd;
						wrl <= cfg_enable_mode_i || !is_rd;
						cnt <= 4'(STB_CYC);
						state <= MHB_H_STB;
					end
				end
				MHB_H_STB: begin
					if (cnt_done) begin
						wrl <= 1'b0;
						rdl <= cfg_enable_mode_i ? is_rd : 1'b0;
						rdata_o <= ad_s2;
						rdata_valid_o <= is_rd && !dummy;
						cnt <= 4'(REL_CYC);
						state <= MHB_H_REL;
					end
				end
				MHB_H_REL: begin
					// Select released only once the strobe is off
					ad_oe <= 1'b0;
					cs <= 1'b0;
					rdl <= 1'b0;
					if (cnt_done) begin
						after_wr <= !is_rd;
						state <= MHB_H_IDLE;
						// After the hidden read the held command still runs
						if (dummy) begin
							dummy <= 1'b0;
							after_wr <= 1'b0;
							addr_ok <= 1'b0;
							is_rd <= pend_rd;
							cs <= 1'b1;
							ale_lo <= first_lo;
							ale_hi <= !first_lo;
							ad_out <= first_lo && cfg_dual_phase_i ?
								{8'h00, tgt_addr[7:0]} :
								first_lo ? tgt_addr :
								{8'h00, tgt_addr[15:8]};
							ad_oe <= 1'b1;
							cnt <= 4'(ALE_CYC);
							state <= MHB_H_ALE1;
						end
					end
				end
				default: begin
					state <= MHB_H_IDLE;
				end
			endcase
		end
	end

	// Pin polarity applied at the boundary; enable-mode direction folded
	assign bus.ale_lo = ale_lo ~^ cfg_ale_pol_i;
	assign bus.ale_hi = ale_hi ~^ cfg_ale_pol_i;
	assign bus.cs = cs ~^ cfg_cs_pol_i;
	assign bus.rd = rdl ~^ cfg_rd_pol_i;
	assign bus.wr = wrl ~^ cfg_wr_pol_i;
	assign bus.ad_host = ad_out;
	assign bus.ad_host_oe = ad_oe;
endmodule // mhb_host

// *** test/mhb_checker.sv ***
// Purpose: Pin-level checks on the link between the host and device ends.
// Assumes: Mode and polarity settings change only while reset is held.
// Notes: Active levels are decoded here from the same settings as the ends.
`timescale 1ns/100ps
module mhb_checker (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic cfg_enable_mode_i,
	input wire logic cfg_ale_qual_i,
	input wire logic cfg_ale_pol_i,
	input wire logic cfg_cs_pol_i,
	input wire logic cfg_rd_pol_i,
	input wire logic cfg_wr_pol_i,
	input wire logic ale_lo_i,
	input wire logic ale_hi_i,
	input wire logic cs_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic ad_host_oe_i,
	input wire logic ad_dev_oe_i
);
	// Active levels of each pin under the chosen polarities
	wire cs_a = (cs_i == cfg_cs_pol_i);
	wire rd_a = (rd_i == cfg_rd_pol_i);
	wire wr_a = (wr_i == cfg_wr_pol_i);
	wire ale_a = (ale_lo_i == cfg_ale_pol_i) || (ale_hi_i == cfg_ale_pol_i);
	wire stb = cfg_enable_mode_i ? wr_a : (rd_a || wr_a);
	wire rd_stb = stb && (cfg_enable_mode_i ? rd_a : !wr_a);
	wire wr_stb = stb && !rd_stb;
	logic last_wr;
	// Kind of the latest strobe; a write may not be followed by an address
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			last_wr <= 1'b0;
		else if (stb)
			last_wr <= wr_stb;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_rd_end;
		$fell(rd_stb);
	endsequence
	sequence s_oe_gone;
		##[1:6] !ad_dev_oe_i;
	endsequence
	a_strobe_needs_cs: assert property (stb |-> cs_a)
		else $error("strobe active without select");
	a_cs_steady_strobe: assert property (
		stb && $past(stb) |-> $stable(cs_i))
		else $error("select moved during strobe");
	a_no_ad_clash: assert property (!(ad_host_oe_i && ad_dev_oe_i))
		else $error("both ends drive the bus");
	a_dev_drive_read: assert property (
		$rose(ad_dev_oe_i) |-> rd_stb && cs_a)
		else $error("device drove bus outside a read");
	a_dev_oe_release: assert property (s_rd_end |-> s_oe_gone)
		else $error("device kept bus after read end");
	a_split_exclusive: assert property (
		!cfg_enable_mode_i |-> !(rd_a && wr_a))
		else $error("read and write strobes together");
	a_ale_no_strobe: assert property (ale_a |-> !stb)
		else $error("latch strobe during data strobe");
	a_ale_qualified: assert property (cfg_ale_qual_i && ale_a |-> cs_a)
		else $error("latch strobe without select");
	a_write_succ: assert property ($rose(ale_a) |-> !last_wr)
		else $error("address phase right after write");
	a_dir_hold: assert property (
		cfg_enable_mode_i && stb && $past(stb) |-> $stable(rd_i))
		else $error("direction moved during enable");
endmodule // mhb_checker

// *** test/testbench.sv ***
// Purpose: Host end against device end across the shared pin bundle.
// Assumes: Device user data is the address folded with a fixed key.
// Notes: Each mode setting is entered under a fresh reset.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; \
	if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
	import mhb_pkg::*;
	localparam logic [DATA_W-1:0] KEY = 16'hA5C3;
	localparam int MAX_CYC = 10000;
	logic clk_i, resetn_i, en_m, qual, dual, hi_f, ale_p, cs_p, rd_p, wr_p;
	logic cmd_valid, cmd_rd, ready, rdata_valid, rd_req, wr_req, busy;
	logic [DATA_W-1:0] cmd_wdata, rdata, rdata_dev, wdata, ev, a, b;
	logic [ADDR_W-1:0] cmd_addr, addr, prev_addr;
	logic [DATA_W-1:0] rd_q[$], wa_q[$], wd_q[$];
	logic prev_wr;
	int err_count, checks_done, seed, cyc, rd_reqs, exp_reqs;
	mhb_if i_mhb_if();
	mhb_host i_mhb_host(.clk_i(clk_i), .resetn_i(resetn_i), .bus(i_mhb_if),
		.cfg_enable_mode_i(en_m), .cfg_dual_phase_i(dual),
		.cfg_hi_first_i(hi_f), .cfg_ale_pol_i(ale_p), .cfg_cs_pol_i(cs_p),
		.cfg_rd_pol_i(rd_p), .cfg_wr_pol_i(wr_p), .cmd_valid_i(cmd_valid),
		.cmd_rd_i(cmd_rd), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
		.ready_o(ready), .rdata_valid_o(rdata_valid), .rdata_o(rdata));
	mhb_dev i_mhb_dev(.clk_i(clk_i), .resetn_i(resetn_i), .bus(i_mhb_if),
		.cfg_enable_mode_i(en_m), .cfg_ale_qual_i(qual),
		.cfg_dual_phase_i(dual), .cfg_ale_pol_i(ale_p), .cfg_cs_pol_i(cs_p),
		.cfg_rd_pol_i(rd_p), .cfg_wr_pol_i(wr_p), .rdata_i(rdata_dev),
		.rd_req_o(rd_req), .wr_req_o(wr_req), .addr_o(addr),
		.wdata_o(wdata), .busy_o(busy));
	mhb_checker i_chk(.clk_i(clk_i), .resetn_i(resetn_i),
		.cfg_enable_mode_i(en_m), .cfg_ale_qual_i(qual),
		.cfg_ale_pol_i(ale_p), .cfg_cs_pol_i(cs_p), .cfg_rd_pol_i(rd_p),
		.cfg_wr_pol_i(wr_p), .ale_lo_i(i_mhb_if.ale_lo),
		.ale_hi_i(i_mhb_if.ale_hi), .cs_i(i_mhb_if.cs),
		.rd_i(i_mhb_if.rd), .wr_i(i_mhb_if.wr),
		.ad_host_oe_i(i_mhb_if.ad_host_oe),
		.ad_dev_oe_i(i_mhb_if.ad_dev_oe));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Device user side answers with the fetched address folded by a key
	always @(posedge clk_i) rdata_dev <= addr ^ KEY;
	// Hang guard: a run far beyond its expected length is a failure
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == MAX_CYC) begin
			err_count++;
			complete_run;
		end
	end
	// Results are sampled mid-cycle, where registered outputs have settled
	always @(negedge clk_i) begin
		if (rdata_valid === 1'b1) begin
			ev = rd_q.size() ? rd_q.pop_front() : 16'hXXXX;
			`CHK("rdata", ev, rdata)
		end
		if (wr_req === 1'b1) begin
			ev = wa_q.size() ? wa_q.pop_front() : 16'hXXXX;
			`CHK("waddr", ev, addr)
			ev = wd_q.size() ? wd_q.pop_front() : 16'hXXXX;
			`CHK("wdata", ev, wdata)
		end
		if (rd_req === 1'b1) begin
			rd_reqs++;
			`CHK("busy", 1'b1, busy)
		end
	end
	task complete_run;
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// New mode set under reset; polarities and qualification are random
	task setup(input int k);
		@(posedge clk_i);
		resetn_i <= 1'b0;
		en_m <= k[0];
		dual <= k[1];
		hi_f <= k[2];
		{qual, ale_p, cs_p, rd_p, wr_p} <= 5'($random(seed));
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		prev_wr = 1'b0;
		rd_reqs = 0;
		exp_reqs = 0;
		@(negedge clk_i);
	endtask
	// One command; the model predicts device reads, including the hidden one
	task run_op(input logic r, input logic [ADDR_W-1:0] ad,
		input logic [DATA_W-1:0] d);
		while (ready !== 1'b1) @(negedge clk_i);
		if (prev_wr && ad != prev_addr)
			exp_reqs++;
		if (r) begin
			exp_reqs++;
			rd_q.push_back(ad ^ KEY);
		end else begin
			wa_q.push_back(ad);
			wd_q.push_back(d);
		end
		prev_wr = !r;
		prev_addr = ad;
		@(posedge clk_i);
		cmd_valid <= 1'b1;
		cmd_rd <= r;
		cmd_addr <= ad;
		cmd_wdata <= d;
		@(posedge clk_i);
		cmd_valid <= 1'b0;
		@(negedge clk_i);
		while (ready !== 1'b1) @(negedge clk_i);
	endtask
	initial begin
		{resetn_i, en_m, qual, dual, hi_f, ale_p, cs_p, rd_p, wr_p} = '0;
		{cmd_valid, cmd_rd, cmd_addr, cmd_wdata} = '0;
		err_count = 0;
		checks_done = 0;
		cyc = 0;
		seed = 54738;
		for (int k = 0; k < 8; k++) begin
			setup(k);
			a = 16'($random(seed));
			b = a ^ 16'h0101;
			run_op(1'b0, a, 16'($random(seed)));
			run_op(1'b0, a, 16'($random(seed)));
			run_op(1'b0, b, 16'($random(seed)));
			run_op(1'b1, b, 16'h0000);
			run_op(1'b1, b, 16'h0000);
			run_op(1'b1, a, 16'h0000);
			run_op(1'b0, a, 16'($random(seed)));
			for (int j = 0; j < 4; j++)
				run_op(1'($random(seed)), 16'($random(seed)), 16'($random(seed)));
			repeat (10) @(negedge clk_i);
			`CHK("rd_reqs", exp_reqs, rd_reqs)
			`CHK("pending", 0, rd_q.size() + wa_q.size())
			`CHK("idle", 1'b0, busy)
		end
		complete_run;
	end
endmodule // testbench
